/* File: inc/pcsr_pkg.sv */
// Constants and helpers shared by the modulator chain and its router
package pcsr_pkg;
   localparam int N_MOD       = 4;
   localparam int REG_W       = 16;
   localparam int CNT_W       = 12;
   localparam int FINE_SHIFT  = 4;
   localparam int SEL_W       = 2;
   localparam int MUX_W       = 4;

   // Control word fields
   localparam int CTL_RUN     = 0;
   localparam int CTL_FOLLOW  = 1;
   localparam int CTL_MUXA    = 4;
   localparam int CTL_MUXB    = 8;

   // Output routing codes
   localparam logic [MUX_W-1:0] MUX_OWN  = 4'h0;
   localparam logic [MUX_W-1:0] MUX_EDGE = 4'h1;
   localparam logic [MUX_W-1:0] MUX_M1C  = 4'h7;
   localparam logic [MUX_W-1:0] MUX_M2C  = 4'h8;

   // Master select codes
   localparam logic [SEL_W-1:0] SEL_M0   = 2'h0;
   localparam logic [SEL_W-1:0] SEL_M1   = 2'h1;
   localparam logic [SEL_W-1:0] SEL_M2   = 2'h2;

   // Address map: bit 7 global, bits 6:5 modulator, bits 4:2 register
   localparam int ADR_W       = 8;
   localparam int ADR_GLOBAL  = 7;
   localparam int ADR_MOD_LSB = 5;
   localparam int ADR_REG_LSB = 2;
   localparam logic [2:0] R_CTRL     = 3'h0;
   localparam logic [2:0] R_PERIOD   = 3'h1;
   localparam logic [2:0] R_A_END    = 3'h2;
   localparam logic [2:0] R_B_BEGIN  = 3'h3;
   localparam logic [2:0] R_B_END    = 3'h4;
   localparam logic [2:0] R_BLK_BEG  = 3'h5;
   localparam logic [2:0] R_BLK_END  = 3'h6;
   localparam logic [2:0] R_TRIG     = 3'h7;
   localparam logic [2:0] G_ROUTING  = 3'h0;
   localparam logic [2:0] G_STATUS   = 3'h1;

   // Reset values
   localparam logic [REG_W-1:0] CTRL_RST   = 16'h0000;
   localparam logic [REG_W-1:0] PERIOD_RST = 16'h0400;
   localparam logic [REG_W-1:0] TIME_RST   = 16'h0000;
   localparam logic [5:0]       ROUTE_RST  = 6'h24;

   localparam logic [CNT_W-1:0] CNT_ONE    = 12'h001;

   // Fine steps to whole clock cycles
   function automatic logic [CNT_W-1:0] to_cyc(input logic [REG_W-1:0] v);
      return v[REG_W-1:FINE_SHIFT];
   endfunction
endpackage

/* File: logic/pcsr_mod.sv */
// One modulator: period counter, A/B/C waveforms, fault qualification
`timescale 1ns/1ps
module pcsr_mod
   import pcsr_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             ce_in,
   input  wire logic             enable_in,
   input  wire logic             follow_in,
   input  wire logic             sync_in,
   input  wire logic [REG_W-1:0] period_in,
   input  wire logic [REG_W-1:0] a_end_in,
   input  wire logic [REG_W-1:0] b_begin_in,
   input  wire logic [REG_W-1:0] b_end_in,
   input  wire logic [REG_W-1:0] c_begin_in,
   input  wire logic [REG_W-1:0] c_end_in,
   input  wire logic [REG_W-1:0] trig_in,
   input  wire logic             fault_pin_in,
   output logic                  a_out,
   output logic                  b_out,
   output logic                  c_out,
   output logic                  sync_out,
   output logic                  fault_out
);
   typedef struct packed {
      logic             fault_meta;
      logic             fault_sync;
      logic [CNT_W-1:0] count;
      logic             a;
      logic             b;
      logic             c;
      logic             sync;
   } pcsr_mod_st_t;

   pcsr_mod_st_t s;
   pcsr_mod_st_t next_s;
   logic [CNT_W-1:0] per_c;
   logic [CNT_W-1:0] trig_c;
   logic [CNT_W-1:0] cb;
   logic [CNT_W-1:0] ce;

   always_comb begin
      next_s = s;
      per_c  = to_cyc(period_in);
      // Zero trigger means the half-period point
      trig_c = (trig_in == TIME_RST) ? (per_c >> 1) : to_cyc(trig_in);
      cb     = to_cyc(c_begin_in);
      ce     = to_cyc(c_end_in);
      next_s.fault_meta = fault_pin_in;
      next_s.fault_sync = s.fault_meta;
      if (!enable_in) begin
         next_s.count = '0;
         next_s.a     = 1'b0;
         next_s.b     = 1'b0;
         next_s.c     = 1'b0;
         next_s.sync  = 1'b0;
      end else begin
         if ((follow_in && sync_in) || (s.count >= per_c - CNT_ONE)) begin
            next_s.count = '0;
         end else begin
            next_s.count = s.count + CNT_ONE;
         end
         next_s.a = (s.count < to_cyc(a_end_in)) && !s.fault_sync;
         next_s.b = (s.count >= to_cyc(b_begin_in)) && (s.count < to_cyc(b_end_in))
                    && !s.fault_sync;
         // Third channel timed by blanking window begin and end, then fault gated
         next_s.c = (s.count >= cb) && (s.count < ce) && !s.fault_sync;
         next_s.sync = (s.count == trig_c);
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s <= '0;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   assign a_out     = s.a;
   assign b_out     = s.b;
   assign c_out     = s.c;
   assign sync_out  = s.sync;
   assign fault_out = s.fault_sync;
endmodule

/* File: logic/pcsr_top.sv */
// Four-modulator phase-shifted chain with output routing and register slave
//
// Behaviour
// - With zero triggers, modulators one to three each restart two cycles after their master's half-period point.
// - A chain select of 0, 1 or 2 picks modulator zero, one or two as master.
// - Identically programmed chained modulators give identical pairs shifted by the master's trigger point plus two cycles.
// - The third channel is routed only after the modulator's fault gating.
// - Modulator three's A pin takes modulator one's third channel at code 7, B pin modulator two's at 8.
// - The third channel edges come from the blanking window begin and end values.
// - Gate waveforms are formed by the routing multiplexer together with the edge generator.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pcsr_top
   import pcsr_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             ce_in,
   input  wire logic [ADR_W-1:0] avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   input  wire logic [3:0]       avs_byteenable_in,
   output logic      [31:0]      avs_readdata_out,
   output logic                  avs_waitrequest_out,
   input  wire logic [N_MOD-1:0] fault_in,
   output logic      [N_MOD-1:0] pwm_a_out,
   output logic      [N_MOD-1:0] pwm_b_out
);
   typedef struct packed {
      logic [N_MOD-1:0][REG_W-1:0] ctrl;
      logic [N_MOD-1:0][REG_W-1:0] period;
      logic [N_MOD-1:0][REG_W-1:0] a_end;
      logic [N_MOD-1:0][REG_W-1:0] b_begin;
      logic [N_MOD-1:0][REG_W-1:0] b_end;
      logic [N_MOD-1:0][REG_W-1:0] blk_beg;
      logic [N_MOD-1:0][REG_W-1:0] blk_end;
      logic [N_MOD-1:0][REG_W-1:0] trig;
      logic [5:0]                  sync_route;
      logic                        ack;
      logic [31:0]                 rdata;
      logic [N_MOD-1:0]            eg_a;
      logic [N_MOD-1:0]            eg_b;
      logic [N_MOD-1:0]            prev_a;
      logic [N_MOD-1:0]            prev_b;
      logic [N_MOD-1:0]            pin_a;
      logic [N_MOD-1:0]            pin_b;
   } pcsr_top_st_t;

   pcsr_top_st_t s;
   pcsr_top_st_t next_s;

   logic [N_MOD-1:0] a_q;
   logic [N_MOD-1:0] b_q;
   logic [N_MOD-1:0] c_q;
   logic [N_MOD-1:0] sync_p;
   logic [N_MOD-1:0] fault_s;
   logic [N_MOD-1:0] msync;
   logic [N_MOD-1:0] follow;

   // Master pulse picked by index
   function automatic logic sel_pulse(input logic [SEL_W-1:0] sel,
                                      input logic [N_MOD-1:0] p);
      logic r;
      r = 1'b0;
      case (sel)
         SEL_M0:  r = p[0];
         SEL_M1:  r = p[1];
         SEL_M2:  r = p[2];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                              input logic [31:0]      wd,
                                              input logic [3:0]       be);
      logic [REG_W-1:0] r;
      r       = old;
      if (be[0]) begin
         r[7:0] = wd[7:0];
      end
      if (be[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Pin source per routing code
   function automatic logic route(input logic [MUX_W-1:0] code,
                                  input logic             own,
                                  input logic             edge_v,
                                  input logic             m1c,
                                  input logic             m2c);
      logic r;
      r = own;
      case (code)
         MUX_OWN:  r = own;
         MUX_EDGE: r = edge_v;
         MUX_M1C:  r = m1c;
         MUX_M2C:  r = m2c;
         default:  r = own;
      endcase
      return r;
   endfunction

   // Modulator zero has no master
   assign msync[0]  = 1'b0;
   assign follow[0] = 1'b0;

   for (genvar k = 1; k < N_MOD; k++) begin : g_chain
      assign msync[k]  = sel_pulse(s.sync_route[SEL_W*(k-1) +: SEL_W], sync_p);
      assign follow[k] = s.ctrl[k][CTL_FOLLOW];
   end

   // Same core for every modulator keeps matched pairs identical
   for (genvar i = 0; i < N_MOD; i++) begin : g_mod
      pcsr_mod pcsr_mod_i (
         .clk_in       (clk_in),
         .reset_in     (reset_in),
         .ce_in        (ce_in),
         .enable_in    (s.ctrl[i][CTL_RUN]),
         .follow_in    (follow[i]),
         .sync_in      (msync[i]),
         .period_in    (s.period[i]),
         .a_end_in     (s.a_end[i]),
         .b_begin_in   (s.b_begin[i]),
         .b_end_in     (s.b_end[i]),
         .c_begin_in   (s.blk_beg[i]),
         .c_end_in     (s.blk_end[i]),
         .trig_in      (s.trig[i]),
         .fault_pin_in (fault_in[i]),
         .a_out        (a_q[i]),
         .b_out        (b_q[i]),
         .c_out        (c_q[i]),
         .sync_out     (sync_p[i]),
         .fault_out    (fault_s[i])
      );
   end

   always_comb begin
      logic [SEL_W-1:0] mi;
      logic [2:0]       ri;
      logic             req;
      logic [REG_W-1:0] rv;
      int               n;
      mi     = avs_address_in[ADR_MOD_LSB +: SEL_W];
      ri     = avs_address_in[ADR_REG_LSB +: 3];
      req    = avs_read_in | avs_write_in;
      rv     = '0;
      n      = 0;
      next_s = s;

      // One wait cycle per access, then acknowledge
      next_s.ack = req & ~s.ack;

      if (avs_address_in[ADR_GLOBAL]) begin
         case (ri)
            G_ROUTING: rv = {10'h000, s.sync_route};
            G_STATUS:  rv = {4'h0, fault_s, s.pin_b, s.pin_a};
            default:   rv = '0;
         endcase
      end else begin
         case (ri)
            R_CTRL:    rv = s.ctrl[mi];
            R_PERIOD:  rv = s.period[mi];
            R_A_END:   rv = s.a_end[mi];
            R_B_BEGIN: rv = s.b_begin[mi];
            R_B_END:   rv = s.b_end[mi];
            R_BLK_BEG: rv = s.blk_beg[mi];
            R_BLK_END: rv = s.blk_end[mi];
            R_TRIG:    rv = s.trig[mi];
            default:   rv = '0;
         endcase
      end

      // Latched during the wait cycle so data stand at the release edge
      if (req && !s.ack) begin
         next_s.rdata = {16'h0000, rv};
      end

      if (avs_write_in && s.ack) begin
         if (avs_address_in[ADR_GLOBAL]) begin
            if (ri == G_ROUTING && avs_byteenable_in[0]) begin
               next_s.sync_route = avs_writedata_in[5:0];
            end
         end else begin
            case (ri)
               R_CTRL:    next_s.ctrl[mi]    = merge(s.ctrl[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_PERIOD:  next_s.period[mi]  = merge(s.period[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_A_END:   next_s.a_end[mi]   = merge(s.a_end[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_B_BEGIN: next_s.b_begin[mi] = merge(s.b_begin[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_B_END:   next_s.b_end[mi]   = merge(s.b_end[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_BLK_BEG: next_s.blk_beg[mi] = merge(s.blk_beg[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_BLK_END: next_s.blk_end[mi] = merge(s.blk_end[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               R_TRIG:    next_s.trig[mi]    = merge(s.trig[mi],
                                                     avs_writedata_in, avs_byteenable_in);
               default:   next_s.ctrl[mi]    = s.ctrl[mi];
            endcase
         end
      end

      // Edge generator: own B rise / next A fall, next B rise / own A fall
      for (int i = 0; i < N_MOD; i++) begin
         n = (i + 1) % N_MOD;
         if (b_q[i] && !s.prev_b[i]) begin
            next_s.eg_a[i] = 1'b1;
         end else if (!a_q[n] && s.prev_a[n]) begin
            next_s.eg_a[i] = 1'b0;
         end
         if (b_q[n] && !s.prev_b[n]) begin
            next_s.eg_b[i] = 1'b1;
         end else if (!a_q[i] && s.prev_a[i]) begin
            next_s.eg_b[i] = 1'b0;
         end
         // Only fault-gated third channels reach the router
         next_s.pin_a[i] = route(s.ctrl[i][CTL_MUXA +: MUX_W], a_q[i], s.eg_a[i],
                                 c_q[1], c_q[2]);
         next_s.pin_b[i] = route(s.ctrl[i][CTL_MUXB +: MUX_W], b_q[i], s.eg_b[i],
                                 c_q[1], c_q[2]);
      end
      next_s.prev_a = a_q;
      next_s.prev_b = b_q;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s            <= '0;
         s.ctrl       <= {N_MOD{CTRL_RST}};
         s.period     <= {N_MOD{PERIOD_RST}};
         s.a_end      <= {N_MOD{TIME_RST}};
         s.b_begin    <= {N_MOD{TIME_RST}};
         s.b_end      <= {N_MOD{TIME_RST}};
         s.blk_beg    <= {N_MOD{TIME_RST}};
         s.blk_end    <= {N_MOD{TIME_RST}};
         s.trig       <= {N_MOD{TIME_RST}};
         s.sync_route <= ROUTE_RST;
      end else if (ce_in) begin
         s <= next_s;
      end
   end

   // Waitrequest is combinational; a frozen edge cannot take a write, so hold it off
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~(s.ack & ce_in);
   assign avs_readdata_out    = s.rdata;
   assign pwm_a_out           = s.pin_a;
   assign pwm_b_out           = s.pin_b;
endmodule

/* File: sim/pcsr_gate_model.sv */
// Gate driver model: pin edge log and fault report lines
`timescale 1ns/1ps
module pcsr_gate_model
   import pcsr_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic [N_MOD-1:0] gate_a_in,
   input  wire logic [N_MOD-1:0] gate_b_in,
   input  wire logic [N_MOD-1:0] trip_in,
   output logic      [N_MOD-1:0] fault_out
);
   int         now = 0;
   int         rise [8] = '{default: 0};
   int         width [8] = '{default: 0};
   int         per [8] = '{default: 0};
   logic [7:0] last = 8'h00;
   logic [7:0] pins;
   assign pins = {gate_b_in, gate_a_in};
   // Desaturation report lags the command by one cycle, like a real driver
   always @(posedge clk_in) begin
      fault_out <= trip_in;
      now <= now + 1;
      last <= pins;
      for (int k = 0; k < 8; k++) begin
         if (pins[k] && !last[k]) begin
            per[k] <= now - rise[k];
            rise[k] <= now;
         end
         if (!pins[k] && last[k]) begin
            width[k] <= now - rise[k];
         end
      end
   end
endmodule

/* File: sim/pcsr_top_properties.sv */
// Checker for the register slave and the routed third channels
`timescale 1ns/1ps
module pcsr_top_properties
   import pcsr_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             ce_in,
   input  wire logic [ADR_W-1:0] avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   input  wire logic [3:0]       avs_byteenable_in,
   input  wire logic [31:0]      avs_readdata_out,
   input  wire logic             avs_waitrequest_out,
   input  wire logic [N_MOD-1:0] fault_in,
   input  wire logic [N_MOD-1:0] pwm_a_out,
   input  wire logic [N_MOD-1:0] pwm_b_out
);
   logic [7:0] mux3;
   logic       req;
   assign req = avs_read_in | avs_write_in;
   // Shadow of modulator three routing codes, taken at the acknowledge edge
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         mux3 <= 8'h00;
      end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h60) begin
         if (avs_byteenable_in[0]) begin
            mux3[3:0] <= avs_writedata_in[7:4];
         end
         if (avs_byteenable_in[1]) begin
            mux3[7:4] <= avs_writedata_in[11:8];
         end
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   new_req_wait_a: assert property ($rose(req) |-> avs_waitrequest_out)
      else $error("new request not held off");
   one_wait_a: assert property (
      req && avs_waitrequest_out && ce_in ##1 ce_in |-> !avs_waitrequest_out)
      else $error("request not answered after one wait");
   idle_free_a: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest without request");
   upper_zero_a: assert property (avs_readdata_out[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   rdata_hold_a: assert property (avs_read_in && !avs_waitrequest_out |=> $stable(avs_readdata_out))
      else $error("read data moved after read");
   ce_stretch_a: assert property (req && !ce_in |-> avs_waitrequest_out)
      else $error("answer given while frozen");
   ce_freeze_a: assert property (!ce_in |=> $stable(pwm_a_out) && $stable(pwm_b_out))
      else $error("pins moved while frozen");
   routed_a_fault_a: assert property (
      (mux3[3:0] == MUX_M1C && fault_in[1]) [*8] |-> !pwm_a_out[3])
      else $error("routed channel A not fault gated");
   routed_b_fault_a: assert property (
      (mux3[7:4] == MUX_M2C && fault_in[2]) [*8] |-> !pwm_b_out[3])
      else $error("routed channel B not fault gated");
endmodule

/* File: sim/tb_pcsr_top.sv */
// Bench for the modulator chain: registers, phasing, routing, edges
`timescale 1ns/1ps
module tb_pcsr_top
   import pcsr_pkg::*;
;
   localparam int P = 32;
   logic             clk_in = 1'b0;
   logic             reset_in = 1'b1;
   logic             ce_in = 1'b1;
   logic [ADR_W-1:0] avs_address = '0;
   logic             avs_read = 1'b0;
   logic             avs_write = 1'b0;
   logic [31:0]      avs_writedata = '0;
   logic [3:0]       avs_byteenable = 4'hF;
   logic [31:0]      avs_readdata;
   logic             avs_waitrequest;
   logic [N_MOD-1:0] fault, pwm_a, pwm_b;
   logic [N_MOD-1:0] trip = '0;
   logic [31:0]      q;
   int               num_errors = 0;
   int               compares = 0;
   int               off;
   int               r;
   always #50 clk_in = ~clk_in;
   pcsr_top pcsr_top_i (.clk_in, .reset_in, .ce_in, .avs_address_in(avs_address),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
      .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
      .avs_waitrequest_out(avs_waitrequest), .fault_in(fault), .pwm_a_out(pwm_a),
      .pwm_b_out(pwm_b));
   pcsr_gate_model pcsr_gate_model_i (.clk_in, .gate_a_in(pwm_a), .gate_b_in(pwm_b),
      .trip_in(trip), .fault_out(fault));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d, compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle cycle behind
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= be;
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_in);
      if (n >= 100) begin
         num_errors++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 16'h0000, 4'hF);
      check(q, exp);
   endtask
   function automatic logic [7:0] adr(input int m, input logic [2:0] rg);
      return {1'b0, m[1:0], rg, 2'b00};
   endfunction
   // Phase of pin k against pin j, folded into one period
   function automatic int ofs(input int k, input int j);
      return ((pcsr_gate_model_i.rise[k] - pcsr_gate_model_i.rise[j]) % P + P) % P;
   endfunction
   task automatic settle();
      repeat (6 * P) @(posedge clk_in);
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      rd(8'h80, 32'(ROUTE_RST));
      rd(adr(2, R_PERIOD), 32'(PERIOD_RST));
      rd(adr(3, R_CTRL), 32'(CTRL_RST));
      wr(8'h84, 16'hFFFF);
      rd(8'h84, 32'h0);
      wr(8'h8C, 16'h1234);
      rd(8'h8C, 32'h0);
      bus(1'b1, adr(0, R_BLK_BEG), 16'hABCD, 4'hE);
      rd(adr(0, R_BLK_BEG), 32'hAB00);
      // Follow bit set on modulator zero too; it must stay free running
      for (int m = 0; m < N_MOD; m++) begin
         wr(adr(m, R_PERIOD), 16'h0200);
         wr(adr(m, R_A_END), 16'h0080);
         wr(adr(m, R_B_BEGIN), 16'h0100);
         wr(adr(m, R_B_END), 16'h0180);
         wr(adr(m, R_CTRL), 16'h0003);
      end
      settle();
      off = ofs(1, 0);
      check(32'(off >= P / 2 && off <= P / 2 + 2), 32'h1);
      check(32'(ofs(2, 1)), 32'(off));
      check(32'(ofs(3, 2)), 32'(off));
      check(32'(ofs(4, 0)), 32'd16);
      for (int k = 0; k < 8; k++) begin
         check(32'(pcsr_gate_model_i.width[k]), 32'd8);
         check(32'(pcsr_gate_model_i.per[k]), 32'(P));
      end
      wr(8'h80, 16'h0004);
      settle();
      check(32'(ofs(3, 0)), 32'(off));
      wr(8'h80, 16'h0024);
      for (int m = 1; m < 3; m++) begin
         r = (m - 1) * 256;
         wr(adr(m, R_BLK_BEG), 16'(r + 4 * 16));
         wr(adr(m, R_BLK_END), 16'(r + 192));
      end
      wr(adr(3, R_CTRL), 16'h0873);
      settle();
      check(32'(ofs(3, 1)), 32'd4);
      check(32'(pcsr_gate_model_i.width[3]), 32'd8);
      check(32'(ofs(7, 2)), 32'd20);
      check(32'(pcsr_gate_model_i.width[7]), 32'd8);
      // A fault on the receiving modulator must not gate borrowed channels
      trip <= 4'b1000;
      settle();
      r = pcsr_gate_model_i.rise[3];
      settle();
      check(32'(pcsr_gate_model_i.rise[3] != r), 32'h1);
      trip <= 4'b0110;
      settle();
      r = pcsr_gate_model_i.rise[3];
      settle();
      check(32'(pcsr_gate_model_i.rise[3]), 32'(r));
      trip <= 4'b0000;
      ce_in <= 1'b0;
      fork
         rd(8'h80, 32'h24);
         begin
            repeat (5) @(posedge clk_in);
            ce_in <= 1'b1;
         end
      join
      wr(adr(2, R_CTRL), 16'h0113);
      settle();
      check(32'(pcsr_gate_model_i.width[2]), 32'(off - 8));
      check(32'(pcsr_gate_model_i.width[6]), 32'(24 - off));
      // Explicit trigger point moves the slave start earlier by the same amount
      wr(adr(0, R_TRIG), 16'h0080);
      settle();
      check(32'(ofs(1, 0)), 32'(off - 8));
      stop_test();
   end
endmodule
bind pcsr_top pcsr_top_properties pcsr_top_properties_i (.clk_in, .reset_in, .ce_in,
   .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_readdata_out, .avs_waitrequest_out, .fault_in, .pwm_a_out, .pwm_b_out);
